//--- core/adsq_defs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef ADSQ_DEFS_SVH
`define ADSQ_DEFS_SVH

// ----------------------------------------
// Register word offsets (byte addresses)
// ----------------------------------------
`define ADSQ_OFS_CTRL0 4'h0
`define ADSQ_OFS_CTRL1 4'h4
`define ADSQ_OFS_PINSEL 4'h8
`define ADSQ_OFS_RESH 4'hC
`define ADSQ_OFS_RESL 4'h0
`define ADSQ_OFS_RESL_HI 2'h1
`define ADSQ_OFS_MISC 4'h4
`define ADSQ_OFS_MISC_HI 2'h1

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ADSQ_C0_START 7
`define ADSQ_C0_BUSY 6
`define ADSQ_C0_PWR 5
`define ADSQ_C0_ALIGN 4
`define ADSQ_C1_REF_HI 4
`define ADSQ_C1_REF_LO 3
`define ADSQ_C1_DIV_HI 2
`define ADSQ_MISC_IRQF 0
`define ADSQ_MISC_IEN 1
`define ADSQ_MISC_GIE 2
`define ADSQ_MISC_VREFPIN 3

// ----------------------------------------
// Reset values and encodings
// ----------------------------------------
`define ADSQ_RST_BYTE 8'h00
`define ADSQ_REF_SUPPLY 2'h1

// ----------------------------------------
// Timing counts in converter clocks
// ----------------------------------------
`define ADSQ_SAMPLE_CLKS 4'h4
`define ADSQ_CONV_CLKS 4'hC

`endif

//--- core/adsq_pkg.sv
// Types shared by the converter sequencer control
`default_nettype none
package adsq_pkg;
	typedef enum logic [2:0] {
		ADSQ_IDLE = 3'b001,
		ADSQ_SAMPLE = 3'b010,
		ADSQ_CONVERT = 3'b100
	} adsq_state_e;

	typedef struct packed {
		logic power_on;
		logic sampling;
		logic use_supply_ref;
		logic vref_pin_analog;
	} adsq_analog_ctl_s;
endpackage
`default_nettype wire

//--- core/adsq_clkdiv.sv
// Converter clock tick generator: system clock divided by a power of two
`include "adsq_defs.svh"
`default_nettype none
module adsq_clkdiv
	import adsq_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic run,
	input wire logic [2:0] div_sel,
	output logic tick
);
	logic [6:0] cnt_q;
	logic [6:0] cnt_d;
	logic [6:0] limit;
	logic wrap;

	assign limit = 7'((8'h01 << div_sel) - 8'h01);
	assign wrap = (cnt_q >= limit);
	assign cnt_d = (!run || wrap) ? 7'h00 : cnt_q + 7'h01;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 7'h00;
			tick <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			tick <= run && wrap;
		end
	end
endmodule
`default_nettype wire

//--- core/adsq_ctrl.sv
// Converter sequencer control with Wishbone register slave
//
// Our own choices: the Wishbone interface to the registers and the address map.
`include "adsq_defs.svh"
`default_nettype none
module adsq_ctrl
	import adsq_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	input wire logic [11:0] conv_result,
	output logic [7:0] analog_channel_inputs,
	output logic [7:0] pin_digital_disable,
	output logic [3:0] channel_select,
	output logic [2:0] input_source_select,
	output adsq_analog_ctl_s analog_ctl,
	output logic result_strobe,
	output logic adc_irq
);
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0] ctrl0_q;
	logic [7:0] ctrl1_q;
	logic [7:0] analog_pin_select_q;
	logic [7:0] res_hi_q;
	logic [7:0] res_lo_q;
	logic irq_flag_q;
	logic irq_en_q;
	logic gie_q;
	logic vref_pin_q;
	logic start_seen_q;
	adsq_state_e state_q;
	adsq_state_e state_d;
	logic [3:0] phase_q;
	logic [3:0] phase_d;
	logic tick;
	logic ack_q;

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	logic req;
	logic sel_c0;
	logic sel_c1;
	logic sel_pin;
	logic sel_res;
	logic hit;
	logic wr_b0;
	logic [31:0] rd_data;
	logic power_on;
	logic start_bit;
	logic launch;
	logic finish;
	logic busy;
	logic left_align;
	logic [11:0] d;

	assign req = wb_cyc_i && wb_stb_i && !ack_q;
	assign sel_c0 = wb_adr_i == `ADSQ_OFS_CTRL0;
	assign sel_c1 = wb_adr_i == `ADSQ_OFS_CTRL1;
	assign sel_pin = wb_adr_i == `ADSQ_OFS_PINSEL;
	assign sel_res = wb_adr_i == `ADSQ_OFS_RESH;
	assign hit = sel_c0 || sel_c1 || sel_pin || sel_res;
	assign wr_b0 = req && wb_we_i && wb_sel_i[0];

	assign power_on = ctrl0_q[`ADSQ_C0_PWR];
	assign start_bit = ctrl0_q[`ADSQ_C0_START];
	assign busy = state_q != ADSQ_IDLE;
	assign left_align = !ctrl0_q[`ADSQ_C0_ALIGN];
	assign d = conv_result;

	// Start fires on the falling edge of a previously raised start bit
	logic start_next;
	assign start_next = (wr_b0 && sel_c0) ? wb_dat_i[`ADSQ_C0_START]
		: start_bit;
	assign launch = start_seen_q && start_bit && !start_next
		&& power_on && !busy;
	assign finish = (state_q == ADSQ_CONVERT) && tick
		&& (phase_q == `ADSQ_CONV_CLKS - 4'h1);

	// Control/status extras live in byte 1 of the control1 word
	assign rd_data = sel_c0 ? {24'h0, ctrl0_q[7], busy, ctrl0_q[5:0]}
		: sel_c1 ? {16'h0, 4'h0, gie_q, vref_pin_q, irq_en_q, irq_flag_q,
			ctrl1_q}
		: sel_pin ? {24'h0, analog_pin_select_q}
		: sel_res ? {16'h0, res_hi_q, res_lo_q}
		: 32'h0000_0000;

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_comb begin
		state_d = state_q;
		phase_d = phase_q;
		unique case (state_q)
			ADSQ_IDLE: begin
				phase_d = 4'h0;
				if (launch) begin
					state_d = ADSQ_SAMPLE;
				end
			end
			ADSQ_SAMPLE: begin
				if (tick) begin
					phase_d = phase_q + 4'h1;
					if (phase_q == `ADSQ_SAMPLE_CLKS - 4'h1) begin
						state_d = ADSQ_CONVERT;
						phase_d = 4'h0;
					end
				end
			end
			ADSQ_CONVERT: begin
				if (tick) begin
					phase_d = phase_q + 4'h1;
					if (finish) begin
						state_d = ADSQ_IDLE;
						phase_d = 4'h0;
					end
				end
			end
			default: begin
				state_d = ADSQ_IDLE;
				phase_d = 4'h0;
			end
		endcase
		if (!power_on) begin
			state_d = ADSQ_IDLE;
			phase_d = 4'h0;
		end
	end

	adsq_clkdiv u_div (
		.clk(clk),
		.rst_n(rst_n),
		.run(busy),
		.div_sel(ctrl1_q[`ADSQ_C1_DIV_HI:0]),
		.tick(tick)
	);

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl0_q <= `ADSQ_RST_BYTE;
			ctrl1_q <= `ADSQ_RST_BYTE;
			analog_pin_select_q <= `ADSQ_RST_BYTE;
			irq_en_q <= 1'b0;
			gie_q <= 1'b0;
			vref_pin_q <= 1'b0;
			start_seen_q <= 1'b0;
		end else begin
			if (wr_b0 && sel_c0) begin
				ctrl0_q <= wb_dat_i[7:0];
			end
			if (wr_b0 && sel_c1) begin
				ctrl1_q <= wb_dat_i[7:0];
			end
			if (wr_b0 && sel_pin) begin
				analog_pin_select_q <= wb_dat_i[7:0];
			end
			if (req && wb_we_i && wb_sel_i[1] && sel_c1) begin
				irq_en_q <= wb_dat_i[9];
				gie_q <= wb_dat_i[10];
				vref_pin_q <= wb_dat_i[11];
			end
			// Low-to-high must be seen before the high-to-low counts
			if (!start_bit) begin
				start_seen_q <= 1'b1;
			end else if (launch || busy) begin
				start_seen_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ADSQ_IDLE;
			phase_q <= 4'h0;
			irq_flag_q <= 1'b0;
			res_hi_q <= `ADSQ_RST_BYTE;
			res_lo_q <= `ADSQ_RST_BYTE;
			result_strobe <= 1'b0;
			adc_irq <= 1'b0;
		end else begin
			state_q <= state_d;
			phase_q <= phase_d;
			result_strobe <= finish;
			// Set beats a simultaneous software clear
			if (finish) begin
				irq_flag_q <= 1'b1;
			end else if (req && wb_we_i && wb_sel_i[1] && sel_c1
				&& !wb_dat_i[8]) begin
				irq_flag_q <= 1'b0;
			end
			if (finish && power_on) begin
				res_hi_q <= left_align ? d[11:4] : {4'h0, d[11:8]};
				res_lo_q <= left_align ? {d[3:0], 4'h0} : d[7:0];
			end
			adc_irq <= (irq_flag_q || finish) && irq_en_q && gie_q;
		end
	end

	// ----------------------------------------
	// Bus answer and analog outputs
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_q <= 1'b0;
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
			analog_channel_inputs <= `ADSQ_RST_BYTE;
			pin_digital_disable <= `ADSQ_RST_BYTE;
			channel_select <= 4'h0;
			input_source_select <= 3'h0;
			analog_ctl <= '0;
		end else begin
			ack_q <= req;
			wb_ack_o <= req && hit;
			wb_err_o <= req && !hit;
			wb_dat_o <= (req && hit && !wb_we_i) ? rd_data : 32'h0000_0000;
			analog_channel_inputs <= analog_pin_select_q;
			pin_digital_disable <= analog_pin_select_q;
			channel_select <= ctrl0_q[3:0];
			input_source_select <= ctrl1_q[7:5];
			analog_ctl.power_on <= power_on;
			analog_ctl.sampling <= state_d == ADSQ_SAMPLE;
			analog_ctl.use_supply_ref <= ctrl1_q[`ADSQ_C1_REF_HI:
				`ADSQ_C1_REF_LO] == `ADSQ_REF_SUPPLY;
			analog_ctl.vref_pin_analog <= vref_pin_q;
		end
	end
endmodule
`default_nettype wire

//--- sim/adsq_core_model.sv
// Far-side stand-in for the analog converter core
`default_nettype none
module adsq_core_model
	import adsq_pkg::*;
(
	input wire logic clk,
	input wire adsq_analog_ctl_s analog_ctl,
	output logic [11:0] conv_result
);
	logic [11:0] junk_q = 12'h000;
	always_ff @(posedge clk) begin
		junk_q <= ~junk_q;
	end
	// Unpowered core toggles so a stray load shows up
	assign conv_result = analog_ctl.power_on ? 12'hb37 : junk_q;
endmodule
`default_nettype wire

//--- sim/adsq_ctrl_assertions.sv
// Port checker for the converter sequencer control
`default_nettype none
module adsq_ctrl_assertions
	import adsq_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic wb_ack_o,
	input wire logic wb_err_o,
	input wire logic [7:0] analog_channel_inputs,
	input wire logic [7:0] pin_digital_disable,
	input wire adsq_analog_ctl_s analog_ctl,
	input wire logic result_strobe
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Request taken at this edge
	wire logic tk = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	wire logic pw = tk && wb_we_i && wb_adr_i == 4'h8 && wb_sel_i[0];
	ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held too long");
	answer_time_a: assert property (tk |=> wb_ack_o != wb_err_o)
		else $error("no single answer after request");
	unmapped_err_a: assert property (tk && wb_adr_i[1:0] != 2'h0 |=> wb_err_o)
		else $error("unmapped access not refused");
	pin_write_a: assert property (
		pw |-> ##2 analog_channel_inputs == $past(wb_dat_i[7:0], 2))
		else $error("pin select write lost");
	pin_digital_a: assert property (
		$stable(analog_channel_inputs) |->
		pin_digital_disable == analog_channel_inputs)
		else $error("digital function not removed");
	samp_power_a: assert property (
		analog_ctl.sampling |-> analog_ctl.power_on)
		else $error("sampling while unpowered");
	samp_len_a: assert property (
		$rose(analog_ctl.sampling) |->
		(analog_ctl.sampling || !analog_ctl.power_on)[*4])
		else $error("sampling phase too short");
	strobe_once_a: assert property (result_strobe |=> !result_strobe)
		else $error("result strobe too long");
	cover property ($rose(analog_ctl.sampling));
	cover property (result_strobe);
	cover property (wb_err_o);
endmodule
bind adsq_ctrl adsq_ctrl_assertions u_chk (.*);
`default_nettype wire

//--- sim/tb_adc_sequencer_control.sv
// Self-checking bench for the converter sequencer control
`default_nettype none
module tb_adc_sequencer_control;
	timeunit 1ns;
	timeprecision 1ps;
	import adsq_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, rd;
	logic wb_ack_o, wb_err_o, result_strobe, adc_irq, er;
	logic [11:0] conv_result;
	logic [7:0] analog_channel_inputs, pin_digital_disable;
	logic [3:0] channel_select;
	logic [2:0] input_source_select;
	adsq_analog_ctl_s analog_ctl;
	int errors = 0, tests_run = 0, n;
	longint t0;
	adsq_ctrl u_dut (.*);
	adsq_core_model u_core (.clk(clk), .analog_ctl(analog_ctl),
		.conv_result(conv_result));
	initial begin
		forever #10 clk = ~clk;
	end
	// ---
	// Shared tasks
	// ---
	task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic final_report();
		$display("checks %0d errors %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic bus(logic we, logic [3:0] a, logic [3:0] s,
		logic [31:0] d);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_sel_i <= s;
		wb_dat_i <= d;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
		rd = wb_dat_o;
		er = wb_err_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		check("answer", n < 20, 1'b1);
		@(posedge clk);
	endtask
	task automatic rdr(logic [3:0] a);
		bus(1'b0, a, 4'hf, 32'h0000_0000);
	endtask
	// Launch, try a relaunch mid-run, then judge the finished conversion
	task automatic cv(logic [7:0] c0, int dv);
		bus(1'b1, 4'h0, 4'h1, {24'h0, c0 | 8'h80});
		rdr(4'h0);
		check("busy early", rd[6], 1'b0);
		bus(1'b1, 4'h0, 4'h1, {24'h0, c0});
		t0 = $time;
		rdr(4'h0);
		check("busy", rd[6], 1'b1);
		bus(1'b1, 4'h0, 4'h1, {24'h0, c0 | 8'h80});
		bus(1'b1, 4'h0, 4'h1, {24'h0, c0});
		n = 0;
		while (result_strobe !== 1'b1 && n < 5000) begin
			@(posedge clk);
			n++;
		end
		n = int'(($time - t0) / 20);
		check("time", n >= (16 << dv) - 2 && n <= (17 << dv) + 3, 1);
		repeat (2) @(posedge clk);
		check("irq", adc_irq, 1'b1);
		rdr(4'h4);
		check("irq flag", rd[8], 1'b1);
		rdr(4'h0);
		check("busy done", rd[6], 1'b0);
		rdr(4'hc);
		check("result", rd[15:0], c0[4] ? 16'h0b37 : 16'hb370);
		bus(1'b1, 4'h4, 4'h2, 32'h0000_0600);
		repeat (2) @(posedge clk);
		check("irq clear", adc_irq, 1'b0);
	endtask
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		for (int a = 0; a < 16; a += 4) begin
			rdr(4'(a));
			check("reset value", rd, 32'h0000_0000);
		end
		bus(1'b1, 4'h9, 4'hf, 32'h0000_00ff);
		check("refused", er, 1'b1);
		bus(1'b1, 4'h8, 4'h1, 32'h0000_00a5);
		rdr(4'h8);
		check("pin select", rd, 32'h0000_00a5);
		check("pin inputs", analog_channel_inputs, 8'ha5);
		check("pin digital", pin_digital_disable, 8'ha5);
		bus(1'b1, 4'h0, 4'h1, 32'h0000_0005);
		bus(1'b1, 4'h4, 4'h1, 32'h0000_00a0);
		repeat (2) @(posedge clk);
		check("channel select", channel_select, 4'h5);
		check("source select", input_source_select, 3'h5);
		for (int r = 0; r < 4; r++) begin
			// Pin function only off the supply reference
			bus(1'b1, 4'h4, 4'h3, {20'h0, r != 1, 3'h6, 3'h0, 2'(r), 3'h0});
			repeat (2) @(posedge clk);
			check("supply ref", analog_ctl.use_supply_ref, r == 1);
			check("vref pin", analog_ctl.vref_pin_analog, r != 1);
		end
		for (int dv = 0; dv < 4; dv += 3) begin
			bus(1'b1, 4'h4, 4'h3, {20'h0, 4'he, 5'h0, 3'(dv)});
			bus(1'b1, 4'h0, 4'h1, {24'h0, 3'h1, dv == 3, 4'h0});
			repeat (20) @(posedge clk);
			cv({3'h1, dv == 3, 4'h0}, dv);
		end
		bus(1'b1, 4'h0, 4'h1, 32'h0000_0090);
		bus(1'b1, 4'h0, 4'h1, 32'h0000_0010);
		repeat (40) @(posedge clk);
		check("power", analog_ctl.power_on, 1'b0);
		rdr(4'h0);
		check("busy off", rd[6], 1'b0);
		rdr(4'hc);
		check("result kept", rd[15:0], 16'h0b37);
		final_report();
	end
	initial begin
		#200_000;
		errors++;
		final_report();
	end
endmodule
`default_nettype wire
